// *** design/peea_params.svh ***
/*
 Constants for the parallel nonvolatile memory host controller.
 Assumes a 50 ns system clock; all pin times are converted to cycles here.
*/
`ifndef PEEA_PARAMS_SVH
`define PEEA_PARAMS_SVH

`define PEEA_CLK_NS 50
`define PEEA_ADDR_W 11
`define PEEA_DATA_W 8
`define PEEA_TOP_BIT 7
`define PEEA_ID_HI 6'h3F
`define PEEA_ID_HI_LSB 5
`define PEEA_TMR_W 18

`define PEEA_T_ACC_NS 150
`define PEEA_T_SU_NS 50
`define PEEA_T_WP_NS 100
`define PEEA_T_DH_NS 10
`define PEEA_T_DB_NS 50
`define PEEA_T_HV_NS 1000
`define PEEA_T_CLR_MS 10
`define PEEA_T_WC_US 1000

`define PEEA_CYC_UP(ns) (((ns) + `PEEA_CLK_NS - 1) / `PEEA_CLK_NS)
`define PEEA_ACC_CYC `PEEA_CYC_UP(`PEEA_T_ACC_NS)
`define PEEA_SU_CYC `PEEA_CYC_UP(`PEEA_T_SU_NS)
`define PEEA_WP_CYC `PEEA_CYC_UP(`PEEA_T_WP_NS)
`define PEEA_DH_CYC `PEEA_CYC_UP(`PEEA_T_DH_NS)
`define PEEA_DB_CYC `PEEA_CYC_UP(`PEEA_T_DB_NS)
`define PEEA_HV_CYC `PEEA_CYC_UP(`PEEA_T_HV_NS)
`define PEEA_CLR_CYC `PEEA_CYC_UP(`PEEA_T_CLR_MS * 1000000)
`define PEEA_WC_CYC `PEEA_CYC_UP(`PEEA_T_WC_US * 1000)

`endif

// *** design/peea_pkg.sv ***
/*
 Types for the parallel nonvolatile memory host controller.
 Assumes peea_params.svh is on the include path.
*/
`include "peea_params.svh"

package peea_pkg;

  typedef enum logic [1:0] {
    PEEA_OP_READ = 2'h0,
    PEEA_OP_WRITE = 2'h1,
    PEEA_OP_CLEAR = 2'h2,
    PEEA_OP_RSVD = 2'h3
  } peea_op_t;

  typedef struct packed {
    peea_op_t op;
    logic id_space;
    logic poll;
    logic [`PEEA_ADDR_W-1:0] addr;
    logic [`PEEA_DATA_W-1:0] data;
  } peea_cmd_t;

  typedef struct packed {
    logic valid;
    logic fail;
    logic [`PEEA_DATA_W-1:0] data;
  } peea_rsp_t;

  typedef enum logic [3:0] {
    PEEA_IDLE = 4'h0,
    PEEA_RD_WAIT = 4'h1,
    PEEA_WR_SETUP = 4'h2,
    PEEA_WR_PULSE = 4'h3,
    PEEA_WR_HOLD = 4'h4,
    PEEA_WAIT_DB = 4'h5,
    PEEA_WAIT_RDY = 4'h6,
    PEEA_POLL_RD = 4'h7,
    PEEA_POLL_GAP = 4'h8,
    PEEA_CLR_SETUP = 4'h9,
    PEEA_CLR_PULSE = 4'hA,
    PEEA_CLR_HOLD = 4'hB
  } peea_state_t;

endpackage

// *** design/peea_timer.sv ***
/*
 Down counter used for every pin timing of the host controller except the write-cycle timeout, which has its own counter.
 Assumes the caller loads it only when it wants a fresh interval.
*/
`timescale 1ns/1ps
`include "peea_params.svh"

module peea_timer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [`PEEA_TMR_W-1:0] value_in,
  output logic expired_out
);

  logic [`PEEA_TMR_W-1:0] count_reg;
  logic [`PEEA_TMR_W-1:0] count_next;

  always_comb begin
    if (load_in) begin
      count_next = value_in;
    end else if (count_reg != '0) begin
      count_next = count_reg - `PEEA_TMR_W'(1);
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expired_out = (count_reg == '0);

endmodule

// *** design/peea_ctrl.sv ***
/*
 Host controller that drives a 2K x 8 parallel nonvolatile memory through its pins:
 reads, self-timed byte writes with ready/busy or top-bit polling, chip clear and
 identification space access. Assumes a 20 MHz clock, synchronous pin inputs and
 external level shifters for the two high-voltage enables.
*/
`timescale 1ns/1ps
`include "peea_params.svh"

module peea_ctrl #(
  parameter logic [`PEEA_TMR_W-1:0] CLR_CYC = `PEEA_TMR_W'(`PEEA_CLR_CYC),
  parameter logic [`PEEA_TMR_W-1:0] WC_CYC = `PEEA_TMR_W'(`PEEA_WC_CYC)
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cmd_valid_in,
  input wire peea_pkg::peea_cmd_t cmd_in,
  output logic cmd_ready_out,
  output peea_pkg::peea_rsp_t rsp_out,
  output logic [`PEEA_ADDR_W-1:0] address_lines_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic oe_hv_out,
  output logic id_space_select_line_hv_out,
  output logic [`PEEA_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n_out,
  input wire logic [`PEEA_DATA_W-1:0] data_lines_in,
  input wire logic rdy_busy_in
);

  localparam int RD_LAT = `PEEA_ACC_CYC + 2;

  peea_pkg::peea_state_t state_reg, state_next;
  peea_pkg::peea_cmd_t cmd_reg, cmd_next;
  peea_pkg::peea_rsp_t rsp_reg, rsp_next;
  logic [`PEEA_ADDR_W-1:0] addr_reg, addr_next;
  logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic oe_hv_reg, oe_hv_next, id_hv_reg, id_hv_next;
  logic [`PEEA_DATA_W-1:0] dout_reg, dout_next;
  logic doe_n_reg, doe_n_next, ready_reg, ready_next;
  logic [`PEEA_TMR_W-1:0] wc_reg, wc_next;
  logic tmr_load, tmr_expired;
  logic [`PEEA_TMR_W-1:0] tmr_value;

  peea_timer u_timer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .expired_out(tmr_expired)
  );

  // Forces an id-space access into the top 32 locations
  function automatic logic [`PEEA_ADDR_W-1:0] map_addr(input peea_pkg::peea_cmd_t c);
    logic [`PEEA_ADDR_W-1:0] a;
    a = c.addr;
    if (c.id_space) begin
      a[`PEEA_ADDR_W-1:`PEEA_ID_HI_LSB] = `PEEA_ID_HI;
    end
    return a;
  endfunction

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    rsp_next = rsp_reg;
    rsp_next.valid = 1'b0;
    addr_next = addr_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    oe_hv_next = oe_hv_reg;
    id_hv_next = id_hv_reg;
    dout_next = dout_reg;
    doe_n_next = doe_n_reg;
    ready_next = ready_reg;
    wc_next = (wc_reg != '0) ? wc_reg - `PEEA_TMR_W'(1) : wc_reg;
    tmr_load = 1'b0;
    tmr_value = '0;
    unique case (state_reg)
      peea_pkg::PEEA_IDLE: begin
        if (cmd_valid_in && ready_reg) begin
          cmd_next = cmd_in;
          ready_next = 1'b0;
          addr_next = map_addr(cmd_in);
          id_hv_next = cmd_in.id_space;
          dout_next = cmd_in.data;
          unique case (cmd_in.op)
            peea_pkg::PEEA_OP_READ: begin
              ce_n_next = 1'b0;
              oe_n_next = 1'b0;
              tmr_load = 1'b1;
              tmr_value = `PEEA_TMR_W'(`PEEA_ACC_CYC);
              state_next = peea_pkg::PEEA_RD_WAIT;
            end
            peea_pkg::PEEA_OP_WRITE: begin
              ce_n_next = 1'b0;
              oe_n_next = 1'b1;
              doe_n_next = 1'b0;
              tmr_load = 1'b1;
              tmr_value = `PEEA_TMR_W'(`PEEA_SU_CYC);
              state_next = peea_pkg::PEEA_WR_SETUP;
            end
            peea_pkg::PEEA_OP_CLEAR: begin
              ce_n_next = 1'b0;
              oe_n_next = 1'b1;
              oe_hv_next = 1'b1;
              id_hv_next = 1'b0;
              tmr_load = 1'b1;
              tmr_value = `PEEA_TMR_W'(`PEEA_HV_CYC);
              state_next = peea_pkg::PEEA_CLR_SETUP;
            end
            peea_pkg::PEEA_OP_RSVD: begin
              // Reserved operation answered at once as failed
              id_hv_next = 1'b0;
              rsp_next.valid = 1'b1;
              rsp_next.fail = 1'b1;
              ready_next = 1'b1;
            end
          endcase
        end
      end
      peea_pkg::PEEA_RD_WAIT: begin
        if (tmr_expired) begin
          rsp_next.valid = 1'b1;
          rsp_next.fail = 1'b0;
          rsp_next.data = data_lines_in;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          id_hv_next = 1'b0;
          ready_next = 1'b1;
          state_next = peea_pkg::PEEA_IDLE;
        end
      end
      peea_pkg::PEEA_WR_SETUP: begin
        if (tmr_expired) begin
          // strobe pulse, address taken on its fall
          we_n_next = 1'b0;
          tmr_load = 1'b1;
          tmr_value = `PEEA_TMR_W'(`PEEA_WP_CYC);
          state_next = peea_pkg::PEEA_WR_PULSE;
        end
      end
      peea_pkg::PEEA_WR_PULSE: begin
        if (tmr_expired) begin
          // data still driven at the rising edge
          we_n_next = 1'b1;
          tmr_load = 1'b1;
          tmr_value = `PEEA_TMR_W'(`PEEA_DH_CYC);
          state_next = peea_pkg::PEEA_WR_HOLD;
        end
      end
      peea_pkg::PEEA_WR_HOLD: begin
        if (tmr_expired) begin
          ce_n_next = 1'b1;
          doe_n_next = 1'b1;
          wc_next = WC_CYC;
          tmr_load = 1'b1;
          tmr_value = `PEEA_TMR_W'(`PEEA_DB_CYC);
          state_next = peea_pkg::PEEA_WAIT_DB;
        end
      end
      peea_pkg::PEEA_WAIT_DB: begin
        // Busy may lag the pulse, so the line is ignored until then
        if (tmr_expired) begin
          state_next = cmd_reg.poll ? peea_pkg::PEEA_POLL_GAP : peea_pkg::PEEA_WAIT_RDY;
        end
      end
      peea_pkg::PEEA_WAIT_RDY: begin
        if (rdy_busy_in || wc_reg == '0) begin
          rsp_next.valid = 1'b1;
          rsp_next.fail = !rdy_busy_in;
          rsp_next.data = cmd_reg.data;
          id_hv_next = 1'b0;
          ready_next = 1'b1;
          state_next = peea_pkg::PEEA_IDLE;
        end
      end
      peea_pkg::PEEA_POLL_GAP: begin
        ce_n_next = 1'b0;
        oe_n_next = 1'b0;
        tmr_load = 1'b1;
        tmr_value = `PEEA_TMR_W'(`PEEA_ACC_CYC);
        state_next = peea_pkg::PEEA_POLL_RD;
      end
      peea_pkg::PEEA_POLL_RD: begin
        if (tmr_expired) begin
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          // top bit matches only once writing is over
          if (data_lines_in[`PEEA_TOP_BIT] == cmd_reg.data[`PEEA_TOP_BIT] || wc_reg == '0) begin
            rsp_next.valid = 1'b1;
            rsp_next.fail = (data_lines_in[`PEEA_TOP_BIT] != cmd_reg.data[`PEEA_TOP_BIT]);
            rsp_next.data = data_lines_in;
            id_hv_next = 1'b0;
            ready_next = 1'b1;
            state_next = peea_pkg::PEEA_IDLE;
          end else begin
            state_next = peea_pkg::PEEA_POLL_GAP;
          end
        end
      end
      peea_pkg::PEEA_CLR_SETUP: begin
        if (tmr_expired) begin
          we_n_next = 1'b0;
          tmr_load = 1'b1;
          tmr_value = CLR_CYC;
          state_next = peea_pkg::PEEA_CLR_PULSE;
        end
      end
      peea_pkg::PEEA_CLR_PULSE: begin
        if (tmr_expired) begin
          we_n_next = 1'b1;
          tmr_load = 1'b1;
          tmr_value = `PEEA_TMR_W'(`PEEA_HV_CYC);
          state_next = peea_pkg::PEEA_CLR_HOLD;
        end
      end
      peea_pkg::PEEA_CLR_HOLD: begin
        if (tmr_expired) begin
          ce_n_next = 1'b1;
          oe_hv_next = 1'b0;
          rsp_next.valid = 1'b1;
          rsp_next.fail = 1'b0;
          ready_next = 1'b1;
          state_next = peea_pkg::PEEA_IDLE;
        end
      end
      default: begin
        state_next = peea_pkg::PEEA_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= peea_pkg::PEEA_IDLE;
      cmd_reg <= '0;
      rsp_reg <= '0;
      addr_reg <= '0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_hv_reg <= 1'b0;
      id_hv_reg <= 1'b0;
      dout_reg <= '0;
      doe_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      wc_reg <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      rsp_reg <= rsp_next;
      addr_reg <= addr_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      oe_hv_reg <= oe_hv_next;
      id_hv_reg <= id_hv_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      ready_reg <= ready_next;
      wc_reg <= wc_next;
    end
  end

  assign cmd_ready_out = ready_reg;
  assign rsp_out = rsp_reg;
  assign address_lines_out = addr_reg;
  assign ce_n_out = ce_n_reg;
  assign oe_n_out = oe_n_reg;
  assign we_n_out = we_n_reg;
  assign oe_hv_out = oe_hv_reg;
  assign id_space_select_line_hv_out = id_hv_reg;
  assign data_lines_out = dout_reg;
  assign data_lines_oe_n_out = doe_n_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_we_needs_oe: assert property (!we_n_out |-> oe_n_out && !ce_n_out)
    else $error("write strobe low without select low and output drive high");
  a_no_bus_fight: assert property (!oe_n_out |-> data_lines_oe_n_out)
    else $error("host drives data while device output is enabled");
  a_data_at_rise: assert property ($rose(we_n_out) && !oe_hv_out |-> !data_lines_oe_n_out)
    else $error("data released before write strobe rose");
  a_addr_in_pulse: assert property (!we_n_out && !$past(we_n_out) |-> $stable(address_lines_out))
    else $error("address moved during write pulse");
  a_pulse_width: assert property ($fell(we_n_out) && !oe_hv_out |-> !we_n_out [*2] ##1 !we_n_out)
    else $error("write pulse shorter than three cycles");
  a_clear_setup: assert property (!we_n_out && oe_hv_out |-> !ce_n_out && data_lines_oe_n_out)
    else $error("chip clear pulse without select or with data driven");
  a_id_window: assert property (id_space_select_line_hv_out && !ce_n_out
      |-> address_lines_out[`PEEA_ADDR_W-1:`PEEA_ID_HI_LSB] == `PEEA_ID_HI)
    else $error("id access outside the top 32 locations");
  a_wait_blocks: assert property ((state_reg == peea_pkg::PEEA_WAIT_RDY || state_reg == peea_pkg::PEEA_POLL_RD)
      |-> !cmd_ready_out && oe_hv_out == 1'b0)
    else $error("new command accepted before write end");
  a_read_latency: assert property (cmd_valid_in && cmd_ready_out && cmd_in.op == peea_pkg::PEEA_OP_READ
      |-> ##[RD_LAT:RD_LAT] rsp_out.valid)
    else $error("read answer not on time");

endmodule

// *** tb/peea_dev_model.sv ***
/*
 Behavioural model of the 2K x 8 parallel nonvolatile memory, seen from its pins.
 Assumes the bench resolves the data lines and the pulled-up ready/busy wire.
*/
`timescale 1ns/1ps
`include "peea_params.svh"

module peea_dev_model #(
  parameter int CLR_NS = 400,
  parameter int PON_NS = 1500
) (
  input wire logic [`PEEA_ADDR_W-1:0] address_lines_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic oe_hv_in,
  input wire logic id_hv_in,
  input wire logic [`PEEA_DATA_W-1:0] host_data_in,
  input wire logic supply_ok_in,
  input wire logic [31:0] write_time_in,
  output logic [`PEEA_DATA_W-1:0] data_lines_out,
  output logic busy_pull_out
);
  logic [7:0] mem [0:2079];
  logic [7:0] lat_data;
  logic [7:0] last_q = 8'h00;
  logic [7:0] rd_val;
  logic busy = 1'b0;
  int lat_idx = 0;
  realtime t_we = 0.0;
  wire logic wr_act = !ce_n_in && !we_n_in && oe_n_in && !oe_hv_in;
  wire logic rd_act = !ce_n_in && !oe_n_in && we_n_in && !oe_hv_in;

  // Main array, then 32 id bytes
  function automatic int idx(input logic id, input logic [10:0] a);
    return (id && a[10:5] == 6'h3F) ? 2048 + int'(a[4:0]) : int'(a);
  endfunction

  initial begin
    for (int i = 0; i < 2080; i++) mem[i] = 8'hFF;
  end

  always @(posedge wr_act) if (!busy) lat_idx = idx(id_hv_in, address_lines_in);

  // Self-timed write
  // Pulses during the wait are missed by this process, so the latches stay put
  always @(negedge wr_act) begin
    if (!busy && supply_ok_in && $realtime >= PON_NS) begin
      lat_data = host_data_in;
      busy = 1'b1;
      mem[lat_idx] = 8'hFF;
      #(write_time_in);
      mem[lat_idx] = lat_data;
      busy = 1'b0;
    end
  end

  assign busy_pull_out = busy;

  // Long strobe with high voltage clears the 2048 main bytes
  always @(negedge we_n_in) t_we = $realtime;
  always @(posedge we_n_in) begin
    if (oe_hv_in && !ce_n_in && $realtime - t_we >= CLR_NS) begin
      for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
    end
  end

  assign rd_val = busy ? ~lat_data : mem[idx(id_hv_in, address_lines_in)];

  // Floating lines show the inverse of the last value
  always @* if (rd_act) last_q = rd_val;
  assign data_lines_out = rd_act ? rd_val : ~last_q;
endmodule

// *** tb/testbench.sv ***
/*
 Self-checking bench for the memory host controller, with a pin-level device model.
 Assumes shortened clear and timeout counts and a pull-up on the ready/busy wire.
*/
`timescale 1ns/1ps
`include "peea_params.svh"

module testbench;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  peea_pkg::peea_cmd_t cmd_in = '0;
  logic cmd_ready_out;
  peea_pkg::peea_rsp_t rsp_out;
  peea_pkg::peea_rsp_t rsp_seen;
  logic [10:0] address_lines_out;
  logic ce_n_out;
  logic oe_n_out;
  logic we_n_out;
  logic oe_hv_out;
  logic id_space_select_line_hv_out;
  logic [7:0] data_lines_out;
  logic data_lines_oe_n_out;
  logic [7:0] data_lines_in;
  logic [7:0] dev_q;
  logic busy_pull;
  logic rdy_busy_in;
  logic supply_ok = 1'b1;
  int wtime = 300;
  int failures = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h42C3D8FD;
  logic [7:0] ref_mem [0:2079];

  assign data_lines_in = !data_lines_oe_n_out ? data_lines_out : dev_q;
  assign rdy_busy_in = !busy_pull;

  peea_ctrl #(.CLR_CYC(18'd8), .WC_CYC(18'd40)) i_peea_ctrl (
    .clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .rsp_out(rsp_out), .address_lines_out(address_lines_out),
    .ce_n_out(ce_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out), .oe_hv_out(oe_hv_out),
    .id_space_select_line_hv_out(id_space_select_line_hv_out), .data_lines_out(data_lines_out),
    .data_lines_oe_n_out(data_lines_oe_n_out), .data_lines_in(data_lines_in), .rdy_busy_in(rdy_busy_in));

  peea_dev_model #(.CLR_NS(400), .PON_NS(1500)) i_peea_dev_model (
    .address_lines_in(address_lines_out), .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
    .oe_hv_in(oe_hv_out), .id_hv_in(id_space_select_line_hv_out), .host_data_in(data_lines_in),
    .supply_ok_in(supply_ok), .write_time_in(wtime), .data_lines_out(dev_q), .busy_pull_out(busy_pull));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_cmd(input peea_pkg::peea_op_t op, input logic id, input logic poll,
                        input logic [10:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{op: op, id_space: id, poll: poll, addr: a, data: d};
    do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    n = 0;
    // A refused operation answers on the take edge itself
    #1;
    while (rsp_out.valid !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 2000) begin
      failures++;
      $display("MISMATCH %0t no response", $time);
    end
    rsp_seen = rsp_out;
  endtask

  task automatic rd_chk(input logic id, input logic [10:0] a);
    do_cmd(peea_pkg::PEEA_OP_READ, id, 1'b0, a, 8'h00);
    check(rsp_seen.data, ref_mem[id ? 2048 + a[4:0] : a]);
  endtask

  task automatic wr_chk(input logic id, input logic poll, input logic [10:0] a, input logic [7:0] d,
                        input logic ef, input logic st);
    do_cmd(peea_pkg::PEEA_OP_WRITE, id, poll, a, d);
    check({7'h00, rsp_seen.fail}, {7'h00, ef});
    if (!ef) check(rsp_seen.data, d);
    if (st) ref_mem[id ? 2048 + a[4:0] : a] = d;
  endtask

  initial begin
    #(20000 * 50);
    failures++;
    $display("MISMATCH %0t watchdog", $time);
    test_done();
  end

  initial begin
    int n;
    logic [10:0] a;
    logic [7:0] d;
    for (int i = 0; i < 2080; i++) ref_mem[i] = 8'hFF;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    // Fast and slow write times, ready and poll detection
    for (int i = 0; i < 12; i++) begin
      seed = lfsr_next(seed);
      a = seed[10:0];
      d = seed[23:16];
      wtime = i[1] ? 1500 : 300;
      wr_chk(1'b0, i[0], a, d, 1'b0, 1'b1);
      rd_chk(1'b0, a);
    end
    // Write outlasts the host timeout; a read meanwhile is a status poll
    for (int p = 0; p < 2; p++) begin
      seed = lfsr_next(seed);
      a = seed[10:0];
      d = seed[31:24];
      wtime = 6000;
      wr_chk(1'b0, p[0], a, d, 1'b1, 1'b0);
      do_cmd(peea_pkg::PEEA_OP_READ, 1'b0, 1'b0, a, 8'h00);
      check({7'h00, rsp_seen.data[7]}, {7'h00, ~d[7]});
      n = 0;
      while (rdy_busy_in !== 1'b1 && n < 1000) begin
        @(posedge clk_in);
        n++;
      end
      check({7'h00, rdy_busy_in}, 8'h01);
      ref_mem[a] = d;
      rd_chk(1'b0, a);
    end
    wtime = 300;
    // Identification bytes are apart from the top of the main array
    seed = lfsr_next(seed);
    wr_chk(1'b1, 1'b0, seed[10:0], 8'h5A, 1'b0, 1'b1);
    rd_chk(1'b1, seed[10:0]);
    rd_chk(1'b0, {6'h3F, seed[4:0]});
    // Low supply: write refused by the device, old byte stays
    supply_ok <= 1'b0;
    wr_chk(1'b0, 1'b0, 11'h123, 8'hA5, 1'b0, 1'b0);
    supply_ok <= 1'b1;
    rd_chk(1'b0, 11'h123);
    // Reserved code refused
    do_cmd(peea_pkg::PEEA_OP_RSVD, 1'b0, 1'b0, 11'h000, 8'h00);
    check({7'h00, rsp_seen.fail}, 8'h01);
    // Chip clear sets every main byte high
    do_cmd(peea_pkg::PEEA_OP_CLEAR, 1'b0, 1'b0, 11'h000, 8'h00);
    check({7'h00, rsp_seen.fail}, 8'h00);
    for (int i = 0; i < 2048; i++) ref_mem[i] = 8'hFF;
    rd_chk(1'b0, a);
    rd_chk(1'b1, seed[10:0]);
    test_done();
  end
endmodule
